// ==== common/isc_pkg.sv ====
package isc_pkg;

  // =====================================================================
  // Register map: indices as printed, byte address is four times the index
  // =====================================================================
  localparam logic [5:0] IDX_MASTER_CTRL  = 6'h03;
  localparam logic [5:0] IDX_SLAVE_CTRL_A = 6'h09;
  localparam logic [5:0] IDX_SLAVE_CTRL_B = 6'h0a;
  localparam logic [5:0] IDX_SLAVE_STATUS = 6'h0b;
  localparam logic [5:0] IDX_OWN_ADDRESS  = 6'h0c;
  localparam logic [5:0] IDX_SLAVE_DATA   = 6'h0d;

  // =====================================================================
  // Field positions
  // =====================================================================
  localparam int MCTRL_ENABLE_BIT   = 0;
  localparam int SCTRLA_ENABLE_BIT  = 0;
  localparam int SCTRLA_STOPEN_BIT  = 5;
  localparam int SLAVE_CONTROL_SECOND_ACK_ACTION_BIT_BIT  = 2;
  localparam int SLAVE_CONTROL_SECOND_CMD_LSB     = 0;
  localparam int STAT_DONE_BIT      = 7;
  localparam int STAT_ADDRSTOP_BIT  = 6;
  localparam int STAT_STRETCH_BIT   = 5;
  localparam int STAT_RECEIVED_ACK_BIT_BIT     = 4;
  localparam int STAT_TRANSMIT_COLLISION_FLAG_BIT      = 3;
  localparam int STAT_BUS_ERROR_FLAG_BIT    = 2;
  localparam int STAT_DIR_BIT       = 1;
  localparam int STAT_CAUSE_BIT     = 0;
  localparam int OWN_GENCALL_BIT    = 0;

  // =====================================================================
  // Reset values and codes
  // =====================================================================
  localparam logic [7:0] OWN_ADDRESS_RESET = 8'h00;
  localparam logic [7:0] SLAVE_DATA_RESET  = 8'h00;
  localparam logic [1:0] NO_ACTION_CODE            = 2'h0;
  localparam logic [1:0] RESERVED_CODE             = 2'h1;
  localparam logic [1:0] COMPLETE_TRANSACTION_CODE = 2'h2;
  localparam logic [1:0] RESPONSE_CODE             = 2'h3;
  localparam logic [3:0] BITS_PER_BYTE             = 4'h8;
  localparam logic [1:0] HTRANS_NONSEQ_MSB         = 2'h2;

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_HOLD,
    ST_ACK_OUT,
    ST_RX,
    ST_TX,
    ST_ACK_IN,
    ST_WAIT_START
  } isc_state_type;

  // What follows an outgoing acknowledge
  typedef enum {
    AFTER_RX,
    AFTER_DATA_HOLD,
    AFTER_WAIT_START
  } isc_after_type;

  typedef struct packed {
    logic slave_byte_done_flag;
    logic address_stop_flag;
    logic clock_stretch_flag;
    logic received_ack_bit;
    logic transmit_collision_flag;
    logic bus_error_flag;
    logic direction;
    logic address_or_stop_cause;
  } isc_status_type;

endpackage

// ==== rtl/isc_slave.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Command field is a write-only strobe, reads zero, each write acts once.
// RULE2: Codes: 0 nothing, 1 reserved, 2 complete transaction, 3 response.
// RULE3: Complete with master-write: send acknowledge action, then idle until a start.
// RULE4: Complete with master-read: send nothing, wait for next start.
// RULE5: Response after address: acknowledge, then receive byte or raise data flag.
// RULE6: Response after data: acknowledge and receive, or transmit byte then take ack.
// RULE7: Acknowledge choice written with a command applies to that command.
// RULE8: Data flag sets at byte end, clean or after a collision.
// RULE9: Data and address/stop flags clear by write-one, data access or command.
// RULE10: Address/stop flag sets on address match or on stop.
// RULE11: Cause bit reads 0 for stop, 1 for address.
// RULE12: Pending address or data flag holds clock low and shows stretch flag.
// RULE13: Received-ack bit keeps the last acknowledge sent by the master.
// RULE14: Failed high bit or NACK sets collision and stops driving lows.
// RULE15: Collision flag clears by write-one or on any start.
// RULE16: Misplaced start, repeated start or stop sets bus error; write-one clears.
// RULE17: Bus error detection only while master section is enabled.
// RULE18: Direction bit holds the read/write bit of the last address.
// RULE19: Software normally clears flags through data accesses or commands.
// RULE20: Acknowledge bit 0 sends ACK, 1 NACK, on data access or command.
// RULE21: Stop sets address/stop flag only when stop enable is 1.
// RULE22: Own address bits 7:1 hold address, bit 0 enables general call.
// RULE23: Reserved command code changes nothing, like the no-action code.
// RULE24: Software waits for a flag before issuing response or complete.
module isc_slave #(
  parameter int SYNC_STAGES = 3
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe
);

  initial
  begin
    if (SYNC_STAGES != 3)
      $error("isc_slave: SYNC_STAGES must be 3");
  end

  // =====================================================================
  // Pin synchronisers
  // =====================================================================
  logic [SYNC_STAGES-1:0] scl_q_r;
  logic [SYNC_STAGES-1:0] sda_q_r;
  logic                   scl_s_r;
  logic                   sda_s_r;
  logic                   scl_prev_r;
  logic                   sda_prev_r;

  // A change counts only once the last two stages agree
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scl_q_r    <= '1;
      sda_q_r    <= '1;
      scl_s_r    <= 1'b1;
      sda_s_r    <= 1'b1;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end
    else
    begin
      scl_q_r    <= {scl_q_r[SYNC_STAGES-2:0], scl_in};
      sda_q_r    <= {sda_q_r[SYNC_STAGES-2:0], sda_in};
      if (scl_q_r[1] == scl_q_r[2])
        scl_s_r <= scl_q_r[2];
      if (sda_q_r[1] == sda_q_r[2])
        sda_s_r <= sda_q_r[2];
      scl_prev_r <= scl_s_r;
      sda_prev_r <= sda_s_r;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign scl_rise   = scl_s_r && !scl_prev_r;
  assign scl_fall   = !scl_s_r && scl_prev_r;
  assign start_seen = scl_s_r && scl_prev_r && !sda_s_r && sda_prev_r;
  assign stop_seen  = scl_s_r && scl_prev_r && sda_s_r && !sda_prev_r;

  // =====================================================================
  // AHB-Lite slave: address phase capture, zero wait states
  // =====================================================================
  logic       dph_valid_r;
  logic       dph_write_r;
  logic [5:0] dph_idx_r;
  logic       master_enable_r;
  logic       slave_enable_r;
  logic       stop_flag_enable_r;
  logic       ack_action_bit_r;
  logic [7:0] own_address_r;
  logic [7:0] slave_data_r;
  isc_pkg::isc_state_type state_r;
  isc_pkg::isc_status_type status;

  logic       wr_en;
  logic       rd_en;
  logic       wr_ctrl_b;
  logic       wr_status;
  logic       data_access;
  logic [1:0] cmd;
  logic       valid_cmd;
  logic       ack_now;

  assign wr_en       = dph_valid_r && dph_write_r;
  assign rd_en       = dph_valid_r && !dph_write_r;
  assign wr_ctrl_b   = wr_en && (dph_idx_r == isc_pkg::IDX_SLAVE_CTRL_B);
  assign wr_status   = wr_en && (dph_idx_r == isc_pkg::IDX_SLAVE_STATUS);
  assign data_access = (wr_en || rd_en) && (dph_idx_r == isc_pkg::IDX_SLAVE_DATA);
  assign cmd         = hwdata[isc_pkg::SLAVE_CONTROL_SECOND_CMD_LSB +: 2];
  // Only codes 2 and 3 act; 0 and 1 fall through untouched [RULE2] [RULE23]
  assign valid_cmd   = wr_ctrl_b && cmd[1];
  // A command takes the acknowledge choice written alongside it [RULE7]
  assign ack_now     = wr_ctrl_b ? hwdata[isc_pkg::SLAVE_CONTROL_SECOND_ACK_ACTION_BIT_BIT] : ack_action_bit_r;

  function automatic logic [31:0] read_value(input logic [5:0] idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (idx)
      isc_pkg::IDX_MASTER_CTRL:  v[isc_pkg::MCTRL_ENABLE_BIT] = master_enable_r;
      isc_pkg::IDX_SLAVE_CTRL_A:
      begin
        v[isc_pkg::SCTRLA_ENABLE_BIT] = slave_enable_r;
        v[isc_pkg::SCTRLA_STOPEN_BIT] = stop_flag_enable_r;
      end
      // Command bits always read zero [RULE1]
      isc_pkg::IDX_SLAVE_CTRL_B: v[isc_pkg::SLAVE_CONTROL_SECOND_ACK_ACTION_BIT_BIT] = ack_action_bit_r;
      isc_pkg::IDX_SLAVE_STATUS: v[7:0] = status;
      isc_pkg::IDX_OWN_ADDRESS:  v[7:0] = own_address_r;
      isc_pkg::IDX_SLAVE_DATA:   v[7:0] = slave_data_r;
      default:                   v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_valid_r <= 1'b0;
      dph_write_r <= 1'b0;
      dph_idx_r   <= 6'h00;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b0;
      hresp       <= 1'b0;
    end
    else
    begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      dph_valid_r <= hsel && hready && (htrans & isc_pkg::HTRANS_NONSEQ_MSB) != 2'h0;
      dph_write_r <= hwrite;
      // Upper address bits are not decoded; unmapped words read zero
      dph_idx_r   <= haddr[7:2];
      hrdata      <= read_value(haddr[7:2]);
    end
  end

  // Control registers written by software
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      master_enable_r    <= 1'b0;
      slave_enable_r     <= 1'b0;
      stop_flag_enable_r <= 1'b0;
      ack_action_bit_r   <= 1'b0;
      own_address_r      <= isc_pkg::OWN_ADDRESS_RESET;
    end
    else if (wr_en)
    begin
      case (dph_idx_r)
        isc_pkg::IDX_MASTER_CTRL:  master_enable_r <= hwdata[isc_pkg::MCTRL_ENABLE_BIT];
        isc_pkg::IDX_SLAVE_CTRL_A:
        begin
          slave_enable_r     <= hwdata[isc_pkg::SCTRLA_ENABLE_BIT];
          stop_flag_enable_r <= hwdata[isc_pkg::SCTRLA_STOPEN_BIT];
        end
        isc_pkg::IDX_SLAVE_CTRL_B: ack_action_bit_r <= hwdata[isc_pkg::SLAVE_CONTROL_SECOND_ACK_ACTION_BIT_BIT];
        isc_pkg::IDX_OWN_ADDRESS:  own_address_r <= hwdata[7:0];
        default:                   own_address_r <= own_address_r;
      endcase
    end
  end

  // =====================================================================
  // Slave sequencer and status flags
  // =====================================================================
  isc_pkg::isc_after_type after_r;
  logic [3:0] bit_cnt_r;
  logic       hold_data_r;
  logic       drive_low_r;
  logic       ack_val_r;
  logic       done_r;
  logic       addr_stop_r;
  logic       received_ack_bit_r;
  logic       transmit_collision_flag_r;
  logic       bus_error_flag_r;
  logic       dir_r;
  logic       cause_r;

  logic       in_hold;
  logic       go_resp;
  logic       go_comp;
  logic       flag_clear;
  logic       addr_match;
  logic       mid_byte;
  logic       byte_end;

  assign in_hold    = (state_r == isc_pkg::ST_HOLD);
  assign go_resp    = in_hold && ((valid_cmd && cmd == isc_pkg::RESPONSE_CODE) || data_access);
  assign go_comp    = in_hold && valid_cmd && cmd == isc_pkg::COMPLETE_TRANSACTION_CODE;
  assign flag_clear = valid_cmd || data_access; // [RULE9]
  // General call only when enabled by the low own-address bit [RULE22]
  assign addr_match = (slave_data_r[7:1] == own_address_r[7:1])
                   || (slave_data_r[7:1] == 7'h00 && own_address_r[isc_pkg::OWN_GENCALL_BIT]);
  assign byte_end   = scl_fall && bit_cnt_r == isc_pkg::BITS_PER_BYTE;
  assign mid_byte   = (state_r == isc_pkg::ST_ADDR || state_r == isc_pkg::ST_RX
                    || state_r == isc_pkg::ST_TX) && bit_cnt_r != 4'h0;

  always_comb
  begin
    status.slave_byte_done_flag    = done_r;
    status.address_stop_flag       = addr_stop_r;
    status.clock_stretch_flag      = in_hold; // [RULE12]
    status.received_ack_bit        = received_ack_bit_r;
    status.transmit_collision_flag = transmit_collision_flag_r;
    status.bus_error_flag          = bus_error_flag_r;
    status.direction               = dir_r;
    status.address_or_stop_cause   = cause_r;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r      <= isc_pkg::ST_IDLE;
      after_r      <= isc_pkg::AFTER_RX;
      bit_cnt_r    <= 4'h0;
      hold_data_r  <= 1'b0;
      drive_low_r  <= 1'b0;
      ack_val_r    <= 1'b0;
      slave_data_r <= isc_pkg::SLAVE_DATA_RESET;
      done_r       <= 1'b0;
      addr_stop_r  <= 1'b0;
      received_ack_bit_r      <= 1'b0;
      transmit_collision_flag_r       <= 1'b0;
      bus_error_flag_r     <= 1'b0;
      dir_r        <= 1'b0;
      cause_r      <= 1'b0;
    end
    else
    begin
      // Clears first; any hardware set below overrides them in the same cycle
      if (flag_clear || (wr_status && hwdata[isc_pkg::STAT_DONE_BIT]))
        done_r <= 1'b0; // [RULE9]
      if (flag_clear || (wr_status && hwdata[isc_pkg::STAT_ADDRSTOP_BIT]))
        addr_stop_r <= 1'b0; // [RULE9]
      if (wr_status && hwdata[isc_pkg::STAT_TRANSMIT_COLLISION_FLAG_BIT])
        transmit_collision_flag_r <= 1'b0; // [RULE15]
      if (wr_status && hwdata[isc_pkg::STAT_BUS_ERROR_FLAG_BIT])
        bus_error_flag_r <= 1'b0; // [RULE16]
      // Writes are refused while a byte is shifting
      if (in_hold && wr_en && dph_idx_r == isc_pkg::IDX_SLAVE_DATA)
        slave_data_r <= hwdata[7:0];

      if (start_seen || stop_seen)
      begin
        // Misplaced conditions need the master-side detector [RULE16] [RULE17]
        if (master_enable_r && (mid_byte || (stop_seen && state_r == isc_pkg::ST_ADDR)))
          bus_error_flag_r <= 1'b1;
        drive_low_r <= 1'b0;
        bit_cnt_r   <= 4'h0;
      end

      if (start_seen)
      begin
        transmit_collision_flag_r  <= 1'b0; // [RULE15]
        state_r <= slave_enable_r ? isc_pkg::ST_ADDR : isc_pkg::ST_IDLE;
      end
      else if (stop_seen)
      begin
        if (stop_flag_enable_r && state_r != isc_pkg::ST_IDLE)
        begin
          addr_stop_r <= 1'b1; // [RULE10] [RULE21]
          cause_r     <= 1'b0; // [RULE11]
        end
        state_r <= isc_pkg::ST_IDLE;
      end
      else
      begin
        case (state_r)
          isc_pkg::ST_ADDR, isc_pkg::ST_RX:
          begin
            if (scl_rise)
            begin
              slave_data_r <= {slave_data_r[6:0], sda_s_r};
              bit_cnt_r    <= bit_cnt_r + 4'h1;
            end
            if (byte_end)
            begin
              bit_cnt_r <= 4'h0;
              if (state_r == isc_pkg::ST_RX)
              begin
                done_r      <= 1'b1; // [RULE8]
                hold_data_r <= 1'b1;
                state_r     <= isc_pkg::ST_HOLD;
              end
              else if (addr_match)
              begin
                dir_r       <= slave_data_r[0]; // [RULE18]
                addr_stop_r <= 1'b1; // [RULE10]
                cause_r     <= 1'b1; // [RULE11]
                hold_data_r <= 1'b0;
                state_r     <= isc_pkg::ST_HOLD;
              end
              else
                state_r <= isc_pkg::ST_WAIT_START;
            end
          end
          isc_pkg::ST_HOLD:
          begin
            // Once both flags are cleared by hand the clock is released and the exchange ends
            if (!done_r && !addr_stop_r)
              state_r <= isc_pkg::ST_WAIT_START; // [RULE12]
            else if (go_comp)
            begin
              if (!dir_r)
              begin
                ack_val_r   <= ack_now; // [RULE3] [RULE20]
                drive_low_r <= !ack_now;
                after_r     <= isc_pkg::AFTER_WAIT_START;
                state_r     <= isc_pkg::ST_ACK_OUT;
              end
              else
                state_r <= isc_pkg::ST_WAIT_START; // [RULE4]
            end
            else if (go_resp)
            begin
              if (hold_data_r && dir_r)
              begin
                drive_low_r <= !((wr_en && dph_idx_r == isc_pkg::IDX_SLAVE_DATA)
                               ? hwdata[7] : slave_data_r[7]); // [RULE6]
                bit_cnt_r   <= 4'h0;
                state_r     <= isc_pkg::ST_TX;
              end
              else
              begin
                ack_val_r   <= ack_now; // [RULE5] [RULE6] [RULE20]
                drive_low_r <= !ack_now;
                after_r     <= (dir_r && !hold_data_r) ? isc_pkg::AFTER_DATA_HOLD
                                                       : isc_pkg::AFTER_RX;
                state_r     <= isc_pkg::ST_ACK_OUT;
              end
            end
          end
          isc_pkg::ST_ACK_OUT:
          begin
            if (scl_rise && ack_val_r && !sda_s_r)
              transmit_collision_flag_r <= 1'b1; // [RULE14]
            if (scl_fall)
            begin
              drive_low_r <= 1'b0;
              bit_cnt_r   <= 4'h0;
              case (after_r)
                isc_pkg::AFTER_RX:         state_r <= isc_pkg::ST_RX;
                isc_pkg::AFTER_DATA_HOLD:
                begin
                  done_r      <= 1'b1; // [RULE5]
                  hold_data_r <= 1'b1;
                  state_r     <= isc_pkg::ST_HOLD;
                end
                default:                   state_r <= isc_pkg::ST_WAIT_START;
              endcase
            end
          end
          isc_pkg::ST_TX:
          begin
            if (scl_rise)
            begin
              if (slave_data_r[7] && !sda_s_r)
                transmit_collision_flag_r <= 1'b1; // [RULE14]
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            if (scl_fall)
            begin
              slave_data_r <= {slave_data_r[6:0], 1'b1};
              drive_low_r  <= (bit_cnt_r == isc_pkg::BITS_PER_BYTE) ? 1'b0 : !slave_data_r[6];
              if (bit_cnt_r == isc_pkg::BITS_PER_BYTE)
                state_r <= isc_pkg::ST_ACK_IN;
            end
          end
          isc_pkg::ST_ACK_IN:
          begin
            if (scl_rise)
              received_ack_bit_r <= sda_s_r; // [RULE13]
            if (scl_fall)
            begin
              done_r      <= 1'b1; // [RULE8]
              hold_data_r <= 1'b1;
              state_r     <= isc_pkg::ST_HOLD;
            end
          end
          isc_pkg::ST_IDLE, isc_pkg::ST_WAIT_START:
            drive_low_r <= 1'b0;
          default:
            state_r <= isc_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // =====================================================================
  // Open-drain pin drivers
  // =====================================================================
  // A collision stops every low on the data line until a start or a write-one clears its flag
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scl_out <= 1'b0;
      scl_oe  <= 1'b0;
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end
    else
    begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe  <= in_hold; // [RULE12]
      sda_oe  <= drive_low_r && !transmit_collision_flag_r; // [RULE14]
    end
  end

endmodule

// ==== test/isc_monitor.sv ====
`timescale 1ns/1ps
module isc_monitor (
  input logic        hclk,
  input logic        hresetn,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hready,
  input logic        hwrite,
  input logic [31:0] hwdata,
  input logic [31:0] hrdata,
  input logic        hreadyout,
  input logic        hresp,
  input logic        scl_out,
  input logic        scl_oe,
  input logic        sda_out,
  input logic        sda_oe
);
  // ====
  // Data phase tracking
  logic       dv_r;
  logic       dw_r;
  logic [5:0] di_r;
  logic [1:0] acc_r;
  logic       rd_cb;
  logic       rd_st;
  logic       rd_oa;
  logic       wr_cb;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      {dv_r, dw_r, di_r, acc_r} <= '0;
    else
      {dv_r, dw_r, di_r, acc_r} <= {hsel & hready & htrans[1], hwrite, haddr[7:2], acc_r[0], dv_r};
  end
  assign rd_cb = dv_r & !dw_r & (di_r == isc_pkg::IDX_SLAVE_CTRL_B);
  assign rd_st = dv_r & !dw_r & (di_r == isc_pkg::IDX_SLAVE_STATUS);
  assign rd_oa = dv_r & !dw_r & (di_r == isc_pkg::IDX_OWN_ADDRESS);
  assign wr_cb = dv_r & dw_r & (di_r == isc_pkg::IDX_SLAVE_CTRL_B);
  default clocking mon_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ====
  // Checks
  cmd_zero_a: assert property (rd_cb |-> hrdata[1:0] == 2'h0)
    else $error("command bits read nonzero");
  held_flag_a: assert property (rd_st && hrdata[5] |-> hrdata[7] || hrdata[6])
    else $error("clock held without a pending flag");
  own_width_a: assert property (rd_oa |-> hrdata[31:8] == 24'h00_0000)
    else $error("own address upper bits nonzero");
  release_why_a: assert property ($fell(scl_oe) |-> dv_r || acc_r != 2'h0)
    else $error("clock released without software access");
  open_drain_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin driven high");
  bus_okay_a: assert property ($past(hresetn) |-> hreadyout && !hresp)
    else $error("bus not ready or not okay");
  weak_cmd_a: assert property (wr_cb && !hwdata[1] && scl_oe |=> scl_oe [*3])
    else $error("idle code released the clock");
  go_cmd_a: assert property (wr_cb && hwdata[1] && scl_oe |-> ##[1:4] !scl_oe)
    else $error("command did not release the clock");
  cover property (wr_cb && hwdata[1:0] == isc_pkg::RESPONSE_CODE);
  cover property ($rose(scl_oe));
  cover property ($rose(sda_oe));
endmodule

// ==== test/isc_bus_master_model.sv ====
`timescale 1ns/1ps
module isc_bus_master_model (
  input  logic scl,
  input  logic sda,
  output logic scl_drv,
  output logic sda_drv
);
  // ====
  // Open-drain master, 80 ns bit, waits while the slave stretches.
  // The low phase is the longer one: the slave only moves its data line
  // about six of its clocks after it has seen the falling clock.
  initial
  begin
    scl_drv = 1'b0;
    sda_drv = 1'b0;
  end
  task pulse(output logic s);
    #28;
    scl_drv = 1'b0;
    wait (scl === 1'b1);
    #12;
    s = sda;
    #12;
    scl_drv = 1'b1;
    #28;
  endtask
  // Also serves as a repeated start after a byte
  task start();
    sda_drv = 1'b0;
    #20;
    scl_drv = 1'b0;
    wait (scl === 1'b1);
    #20;
    sda_drv = 1'b1;
    #40;
    scl_drv = 1'b1;
    #20;
  endtask
  task stop();
    sda_drv = 1'b1;
    #20;
    scl_drv = 1'b0;
    wait (scl === 1'b1);
    #40;
    sda_drv = 1'b0;
    #40;
  endtask
  // Data 8'hff releases the line so the slave may send
  task xfer(input logic [7:0] d, input logic a_in, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
    begin
      sda_drv = !d[i];
      pulse(q[i]);
    end
    sda_drv = !a_in;
    pulse(a);
    sda_drv = 1'b0;
  endtask
endmodule

// ==== test/test_isc_slave.sv ====
`timescale 1ns/1ps
module test_isc_slave;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic        scl_out, scl_oe, sda_out, sda_oe, m_scl, m_sda, ack;
  logic [7:0]  q;
  int          miscompares = 0;
  int          n_compared = 0;
  wire         scl = !(m_scl | scl_oe);
  wire         sda = !(m_sda | sda_oe);
  isc_slave uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
  isc_bus_master_model m (.scl(scl), .sda(sda), .scl_drv(m_scl), .sda_drv(m_sda));
  always #4 hclk = ~hclk;
  // ====
  // Helpers
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    @(posedge hclk);
    {hsel, htrans, hwrite} <= {1'b1, isc_pkg::HTRANS_NONSEQ_MSB, w};
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans} <= 3'h0;
    hwdata <= {24'h00_0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task look(input logic [7:0] a, input logic [7:0] msk, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    check(r & {24'hff_ffff, msk}, {24'h00_0000, e});
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  // Status polling; the run timeout bounds a slave that never answers
  task wait_st(input logic [7:0] msk);
    logic [31:0] r;
    r = 32'h0000_0000;
    while ((r[7:0] & msk) == 8'h00)
      bus(1'b0, 8'h2c, 8'h00, r);
  endtask
  task print_verdict();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ====
  // Scenarios
  task t_regs();
    look(8'h2c, 8'hff, 8'h00);
    wr(8'h30, 8'h54);
    look(8'h30, 8'hff, 8'h54);
    wr(8'h28, 8'h07);
    look(8'h28, 8'hff, 8'h04);
    look(8'h3c, 8'hff, 8'h00);
    wr(8'h28, 8'h00);
    wr(8'h0c, 8'h01);
    wr(8'h24, 8'h21);
    $display("register test done");
  endtask
  task t_write();
    fork
      begin
        m.start();
        m.xfer(8'h54, 1'b1, q, ack);
      end
      begin
        wait_st(8'h40);
        look(8'h2c, 8'hff, 8'h61);
        wr(8'h28, 8'h01);
        look(8'h2c, 8'hff, 8'h61);
        wr(8'h28, 8'h03);
      end
    join
    check(ack, 1'b0);
    fork
      m.xfer(8'ha5, 1'b1, q, ack);
      begin
        wait_st(8'h80);
        look(8'h2c, 8'hfe, 8'ha0);
        look(8'h34, 8'hff, 8'ha5);
      end
    join
    check(ack, 1'b0);
    fork
      m.xfer(8'h3c, 1'b1, q, ack);
      begin
        wait_st(8'h80);
        wr(8'h28, 8'h06);
        look(8'h2c, 8'he0, 8'h00);
      end
    join
    check(ack, 1'b1);
    m.stop();
    look(8'h2c, 8'hc1, 8'h40);
    wr(8'h2c, 8'h40);
    look(8'h2c, 8'h40, 8'h00);
    $display("write test done");
  endtask
  task t_read();
    logic [7:0] tx [3] = '{8'hc3, 8'h5a, 8'hff};
    logic [7:0] dr [3] = '{8'hff, 8'hff, 8'h00};
    logic       ma [3] = '{1'b0, 1'b1, 1'b0};
    logic [7:0] st [3] = '{8'h80, 8'h90, 8'h88};
    fork
      begin
        m.start();
        m.xfer(8'h55, 1'b1, q, ack);
      end
      begin
        wait_st(8'h40);
        look(8'h2c, 8'hff, 8'h63);
        wr(8'h28, 8'h03);
      end
    join
    check(ack, 1'b0);
    wait_st(8'h80);
    look(8'h2c, 8'ha2, 8'ha2);
    // Last byte: the master pulls data low against the slave's ones
    for (int i = 0; i < 3; i++)
    begin
      fork
        m.xfer(dr[i], ma[i], q, ack);
        wr(8'h34, tx[i]);
      join
      check(q, tx[i] & dr[i]);
      wait_st(8'h80);
      look(8'h2c, 8'h98, st[i]);
    end
    wr(8'h28, 8'h02);
    look(8'h2c, 8'h20, 8'h00);
    check(sda_oe, 1'b0);
    m.start();
    look(8'h2c, 8'h08, 8'h00);
    m.stop();
    look(8'h2c, 8'h04, 8'h04);
    wr(8'h2c, 8'hc4);
    look(8'h2c, 8'h04, 8'h00);
    wr(8'h0c, 8'h00);
    m.start();
    m.stop();
    look(8'h2c, 8'h04, 8'h00);
    $display("read test done");
  endtask
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_write();
    t_read();
    print_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    print_verdict();
  end
endmodule
bind isc_slave isc_monitor mon (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hready(hready), .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_out(sda_out), .sda_oe(sda_oe));
